/* inc/wdl_pkg.sv */
// wdl_pkg: register map, field layout, reset values and encodings of the watchdog block
package wdl_pkg;
  // register indices (byte address = 4 * index)
  localparam logic [3:0] IDX_CTRL = 4'h0;
  localparam logic [3:0] IDX_PERIOD_REGISTER = 4'h1;
  localparam logic [3:0] IDX_COUNTER_REGISTER = 4'h2;
  localparam int ADDR_W = 4;
  localparam int ADDR_LSB = 2;
  // control field positions
  localparam int CTL_WP = 0;
  localparam int CTL_EN = 1;
  localparam int CTL_WEN = 2;
  localparam int CTL_SEN = 3;
  localparam int CTL_LOREN = 4;
  localparam int CTL_CSEL_LO = 5;
  localparam int CTL_PSS_LO = 8;
  localparam logic [9:0] CTL_RESET = 10'h302;
  localparam logic [9:0] CTL_WMASK = 10'h37f;
  localparam logic [15:0] PERIOD_REGISTER_RESET = 16'hffff;
  localparam logic [15:0] PAT_FIRST = 16'h5555;
  localparam logic [15:0] PAT_SECOND = 16'haaaa;
  localparam logic [6:0] LOR_MAX = 7'h7f;
  localparam logic [1:0] CSEL_RELAXATION_OSC_CLOCK = 2'h0;
  localparam logic [1:0] CSEL_CRYSTAL_OSC_CLOCK = 2'h1;
  localparam logic [1:0] CSEL_BUS = 2'h2;
  localparam logic [1:0] PSS_DIV1 = 2'h0;
  localparam logic [1:0] PSS_DIV16 = 2'h1;
  localparam logic [1:0] PSS_DIV256 = 2'h2;
  localparam logic [9:0] DIV16_MASK = 10'h00f;
  localparam logic [9:0] DIV256_MASK = 10'h0ff;
  localparam logic [9:0] DIV1024_MASK = 10'h3ff;
  localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
endpackage

/* src/wdl_watchdog.sv */
// wdl_watchdog: watchdog counter with loss-of-reference reset and Avalon-MM registers
//------------------------------------------------------------------
//------------------------------------------------------------------
`timescale 1ns/100ps
module wdl_watchdog #(
  // counter widths; the register map fixes them at these values
  parameter int PERIOD_REGISTER_W = 16,
  parameter int LOR_W = 7,
  parameter int PRE_W = 10
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // avalon-mm slave
  input wire logic [3:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsWriteData,
  input wire logic [3:0] avsByteEnable,
  output logic [31:0] avsReadData,
  output logic avsWaitRequest,
  // chip mode and clock monitor
  input wire logic waitMode,
  input wire logic stopMode,
  input wire logic debugMode,
  input wire logic lossOfRef,
  input wire logic crystalOscClock,
  input wire logic relaxationOscClock,
  // chip reset requests
  output logic wdResetOut_n,
  output logic lossrefResetOut_n
);
  // reset release
  logic rstSync1_q, rstSync_b;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rstSync1_q <= 1'b0;
      rstSync_b <= 1'b0;
    end else begin
      rstSync1_q <= 1'b1;
      rstSync_b <= rstSync1_q;
    end
  end

  //------------------------------------------------------------------
  // parameter checks
  //------------------------------------------------------------------
  // patterns, register fields and prescaler masks have fixed widths
  if (PERIOD_REGISTER_W != 16) begin : g_bad_period_register_w
    $error("wdl_watchdog: PERIOD_REGISTER_W must be 16");
  end
  if (LOR_W != 7) begin : g_bad_lor_w
    $error("wdl_watchdog: LOR_W must be 7");
  end
  if (PRE_W != 10) begin : g_bad_pre_w
    $error("wdl_watchdog: PRE_W must be 10");
  end

  //------------------------------------------------------------------
  // pin synchronisers
  //------------------------------------------------------------------
  // second and third stages must agree before a change counts
  localparam int NSYNC = 5;
  logic [NSYNC-1:0] pinRaw;
  wire [NSYNC-1:0] pinClean;
  assign pinRaw = {relaxationOscClock, crystalOscClock, lossOfRef, stopMode, waitMode};
  for (genvar g = 0; g < NSYNC; g++) begin : g_pin_sync
    logic s1_q, s2_q, s3_q, clean_q;
    always_ff @(posedge sys_clk or negedge rstSync_b) begin
      if (!rstSync_b) begin
        s1_q <= 1'b0;
        s2_q <= 1'b0;
        s3_q <= 1'b0;
      end else begin
        s1_q <= pinRaw[g];
        s2_q <= s1_q;
        s3_q <= s2_q;
      end
    end
    // a single disagreeing sample is taken as noise and ignored
    always_ff @(posedge sys_clk or negedge rstSync_b) begin
      if (!rstSync_b) begin
        clean_q <= 1'b0;
      end else if (s2_q == s3_q) begin
        clean_q <= s3_q;
      end
    end
    assign pinClean[g] = clean_q;
  end
  logic waitS, stopS, lorS, coscS, roscS;
  assign waitS = pinClean[0];
  assign stopS = pinClean[1];
  assign lorS = pinClean[2];
  assign coscS = pinClean[3];
  assign roscS = pinClean[4];
  // debug comes from on-chip logic on this clock
  logic dbg;
  assign dbg = debugMode;

  //------------------------------------------------------------------
  // bus slave: one wait state, answer in the second cycle
  //------------------------------------------------------------------
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ANSWER = 2'b10
  } wdl_bus_e;
  wdl_bus_e busState_q;
  logic busReq, acc, answering;
  assign answering = (busState_q == BUS_ANSWER);
  assign busReq = (avsRead | avsWrite) & ~answering;
  assign acc = avsWrite & answering;
  always_ff @(posedge sys_clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      busState_q <= BUS_IDLE;
    end else begin
      unique case (busState_q)
        BUS_IDLE: begin
          if (avsRead | avsWrite) begin
            busState_q <= BUS_ANSWER;
          end
        end
        BUS_ANSWER: begin
          // the answer lasts one cycle; the master releases at that edge
          busState_q <= BUS_IDLE;
        end
        default: begin
          busState_q <= BUS_IDLE;
        end
      endcase
    end
  end
  // own flop so the port comes straight from a register
  always_ff @(posedge sys_clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      avsWaitRequest <= 1'b1;
    end else begin
      avsWaitRequest <= ~busReq;
    end
  end
  function automatic logic hitReg(input logic [3:0] a, input logic [3:0] idx);
    hitReg = (a[3:wdl_pkg::ADDR_LSB] == idx[1:0]) && (a[1:0] == 2'h0);
  endfunction
  logic wrCtrl, wrTout, wrCntr, lowLanes;
  assign lowLanes = avsByteEnable[0] & avsByteEnable[1];
  assign wrCtrl = acc & lowLanes & hitReg(avsAddress, wdl_pkg::IDX_CTRL);
  assign wrTout = acc & lowLanes & hitReg(avsAddress, wdl_pkg::IDX_PERIOD_REGISTER);
  assign wrCntr = acc & lowLanes & hitReg(avsAddress, wdl_pkg::IDX_COUNTER_REGISTER);

  //------------------------------------------------------------------
  // control and timeout registers
  //------------------------------------------------------------------
  logic [9:0] ctrl_q;
  logic [PERIOD_REGISTER_W-1:0] period_register_q;
  logic wp, en, wen, sen, loren;
  logic [1:0] csel, prescale_select;
  assign wp = ctrl_q[wdl_pkg::CTL_WP];
  assign en = ctrl_q[wdl_pkg::CTL_EN];
  assign wen = ctrl_q[wdl_pkg::CTL_WEN];
  assign sen = ctrl_q[wdl_pkg::CTL_SEN];
  assign loren = ctrl_q[wdl_pkg::CTL_LOREN];
  assign csel = ctrl_q[wdl_pkg::CTL_CSEL_LO +: 2];
  assign prescale_select = ctrl_q[wdl_pkg::CTL_PSS_LO +: 2];
  always_ff @(posedge sys_clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      ctrl_q <= wdl_pkg::CTL_RESET;
    end else if (wrCtrl && !wp) begin
      ctrl_q <= avsWriteData[9:0] & wdl_pkg::CTL_WMASK;
    end
  end
  always_ff @(posedge sys_clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      period_register_q <= wdl_pkg::PERIOD_REGISTER_RESET;
    end else if (wrTout && !wp) begin
      period_register_q <= avsWriteData[15:0];
    end
  end

  //------------------------------------------------------------------
  // service sequence
  //------------------------------------------------------------------
  typedef enum logic [1:0] {
    SVC_FIRST = 2'b01,
    SVC_SECOND = 2'b10
  } wdl_svc_e;
  wdl_svc_e svcState_q;
  logic serviced, firstSeen;
  assign firstSeen = (avsWriteData[15:0] == wdl_pkg::PAT_FIRST);
  assign serviced = wrCntr && (svcState_q == SVC_SECOND)
    && (avsWriteData[15:0] == wdl_pkg::PAT_SECOND);
  always_ff @(posedge sys_clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      svcState_q <= SVC_FIRST;
    end else if (wrCntr) begin
      // other registers leave tracking alone bad data restarts it
      unique case (svcState_q)
        SVC_FIRST: svcState_q <= firstSeen ? SVC_SECOND : SVC_FIRST;
        SVC_SECOND: svcState_q <= firstSeen ? SVC_SECOND : SVC_FIRST;
        default: svcState_q <= SVC_FIRST;
      endcase
    end
  end

  //------------------------------------------------------------------
  // timebase: source select and prescaler
  //------------------------------------------------------------------
  logic srcLvl, srcLvl_q, srcEdge;
  always_comb begin
    unique case (csel)
      wdl_pkg::CSEL_RELAXATION_OSC_CLOCK: srcLvl = roscS;
      wdl_pkg::CSEL_CRYSTAL_OSC_CLOCK: srcLvl = coscS;
      default: srcLvl = 1'b0;
    endcase
  end
  always_ff @(posedge sys_clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      srcLvl_q <= 1'b0;
    end else begin
      srcLvl_q <= srcLvl;
    end
  end
  // oscillators are sampled as data through the filter, so they must stay at or below a quarter of sys_clk
  assign srcEdge = (csel == wdl_pkg::CSEL_BUS) ? 1'b1 : (srcLvl & ~srcLvl_q);
  // ratio code to the prescaler bits that must all be one for a tick
  function automatic logic [PRE_W-1:0] ratioMask(input logic [1:0] code);
    unique case (code)
      wdl_pkg::PSS_DIV1: ratioMask = '0;
      wdl_pkg::PSS_DIV16: ratioMask = wdl_pkg::DIV16_MASK;
      wdl_pkg::PSS_DIV256: ratioMask = wdl_pkg::DIV256_MASK;
      default: ratioMask = wdl_pkg::DIV1024_MASK;
    endcase
  endfunction
  logic [PRE_W-1:0] divMask, pre_q;
  assign divMask = ratioMask(prescale_select);

  //------------------------------------------------------------------
  // watchdog counter
  //------------------------------------------------------------------
  logic running, tick, enPrev_q, stopped;
  logic [PERIOD_REGISTER_W-1:0] count_q;
  // run permission is shared by counting and by the reload decision
  function automatic logic modeRun(input logic e, input logic w, input logic we,
      input logic s, input logic se);
    modeRun = e && (!w || we) && (!s || se);
  endfunction
  // wait/stop keep counting only with their run bit set
  assign running = modeRun(en, waitS, wen, stopS, sen) && !dbg;
  assign stopped = !modeRun(en, waitS, wen, stopS, sen);
  assign tick = running && srcEdge && ((pre_q & divMask) == divMask);
  always_ff @(posedge sys_clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      pre_q <= '0;
    end else if (!running) begin
      pre_q <= '0;
    end else if (srcEdge) begin
      pre_q <= (pre_q & divMask) == divMask ? 10'h000 : pre_q + 10'h001;
    end
  end
  always_ff @(posedge sys_clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      enPrev_q <= 1'b0;
    end else begin
      enPrev_q <= en;
    end
  end
  always_ff @(posedge sys_clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      count_q <= wdl_pkg::PERIOD_REGISTER_RESET;
    end else if (serviced || (en && !enPrev_q) || stopped) begin
      count_q <= period_register_q;
    end else if (tick && count_q != '0) begin
      count_q <= count_q - 16'h0001;
    end
  end

  //------------------------------------------------------------------
  // watchdog reset request
  //------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      wdResetOut_n <= 1'b1;
    end else if (running && count_q == '0) begin
      wdResetOut_n <= 1'b0;
    end
  end

  //------------------------------------------------------------------
  // loss-of-reference counter
  //------------------------------------------------------------------
  typedef enum logic [1:0] {
    LOR_IDLE = 2'b01,
    LOR_RUN = 2'b10
  } wdl_lor_e;
  wdl_lor_e lorState_q;
  logic lorCounting;
  logic [LOR_W-1:0] lor_q;
  always_ff @(posedge sys_clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      lorState_q <= LOR_IDLE;
    end else if (!loren) begin
      lorState_q <= LOR_IDLE;
    end else begin
      unique case (lorState_q)
        LOR_IDLE: lorState_q <= lorS ? LOR_RUN : LOR_IDLE;
        // once started it runs on even if the reference comes back
        LOR_RUN: lorState_q <= LOR_RUN;
        default: lorState_q <= LOR_IDLE;
      endcase
    end
  end
  assign lorCounting = (lorState_q == LOR_RUN) || lorS;
  always_ff @(posedge sys_clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      lor_q <= '0;
    end else if (!loren || serviced) begin
      lor_q <= '0;
    end else if (lorCounting && lor_q != wdl_pkg::LOR_MAX) begin
      lor_q <= lor_q + 7'h01;
    end
  end
  always_ff @(posedge sys_clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      lossrefResetOut_n <= 1'b1;
    end else if (lor_q == wdl_pkg::LOR_MAX && loren) begin
      lossrefResetOut_n <= 1'b0;
    end
  end

  //------------------------------------------------------------------
  // read data
  //------------------------------------------------------------------
  // enable reads as zero while debugging; the stored bit is untouched
  function automatic logic [9:0] ctrlView(input logic [9:0] c, input logic d);
    ctrlView = c;
    if (d) begin
      ctrlView[wdl_pkg::CTL_EN] = 1'b0;
    end
  endfunction
  always_ff @(posedge sys_clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      avsReadData <= '0;
    end else if (busReq && avsRead) begin
      if (hitReg(avsAddress, wdl_pkg::IDX_CTRL)) begin
        avsReadData <= {22'h0, ctrlView(ctrl_q, dbg)};
      end else if (hitReg(avsAddress, wdl_pkg::IDX_PERIOD_REGISTER)) begin
        avsReadData <= {16'h0, period_register_q};
      end else if (hitReg(avsAddress, wdl_pkg::IDX_COUNTER_REGISTER)) begin
        avsReadData <= {16'h0, count_q};
      end else begin
        avsReadData <= wdl_pkg::UNMAPPED_DATA;
      end
    end
  end
endmodule // wdl_watchdog

/* test/wdl_clk_monitor.sv */
// wdl_clk_monitor: oscillator outputs and loss-of-reference signal toward the watchdog
`timescale 1ns/100ps
module wdl_clk_monitor (
  // clock and command
  input wire logic sys_clk,
  input wire logic lorReq,
  // toward the watchdog
  output logic crystalOscClock,
  output logic relaxationOscClock,
  output logic lossOfRef
);
  logic [3:0] div_q;
  initial begin
    div_q = 4'h0;
    crystalOscClock = 1'b0;
    relaxationOscClock = 1'b0;
    lossOfRef = 1'b0;
  end
  // oscillators well below half the bus clock so every edge is sampled
  always @(posedge sys_clk) begin
    div_q <= div_q + 4'h1;
    crystalOscClock <= div_q[1];
    relaxationOscClock <= div_q[2];
    lossOfRef <= lorReq;
  end
endmodule // wdl_clk_monitor

/* test/wdl_watchdog_asserts.sv */
// wdl_watchdog_asserts: port-level checks of the watchdog block
`timescale 1ns/100ps
module wdl_watchdog_chk (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // bus
  input wire logic [3:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsReadData,
  input wire logic avsWaitRequest,
  // chip side
  input wire logic debugMode,
  input wire logic wdResetOut_n,
  input wire logic lossrefResetOut_n
);
  logic wpSeen_q;
  logic [7:0] sinceRst_q;
  wire ctrlRd = avsRead && !avsWaitRequest && avsAddress == 4'h0;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) wpSeen_q <= 1'b0;
    else if (ctrlRd && avsReadData[0]) wpSeen_q <= 1'b1;
  end
  // saturates, only the early window after release matters
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) sinceRst_q <= 8'h00;
    else if (sinceRst_q != 8'hff) sinceRst_q <= sinceRst_q + 8'h01;
  end
  a_wait_low_next:
  assert property (($rose(avsRead) || $rose(avsWrite)) |=> !avsWaitRequest)
  else $error("request not answered after one wait state");
  a_wait_one_low:
  assert property (!avsWaitRequest |=> avsWaitRequest) else $error("waitrequest low too long");
  a_wait_idle_high:
  assert property (!avsRead && !avsWrite |=> avsWaitRequest) else $error("answer without request");
  a_wd_sticky:
  assert property (!wdResetOut_n |=> !wdResetOut_n) else $error("watchdog reset released");
  a_lor_sticky:
  assert property ($fell(lossrefResetOut_n) |=> !lossrefResetOut_n [*4])
  else $error("lossref reset released");
  a_reset_clears:
  assert property (@(posedge sys_clk) disable iff (1'b0)
    !rst_b |=> wdResetOut_n && lossrefResetOut_n) else $error("reset outs not cleared");
  a_ctrl_debug:
  assert property (ctrlRd && debugMode |-> !avsReadData[1]) else $error("enable read in debug");
  a_wp_sticky:
  assert property (ctrlRd && wpSeen_q |-> avsReadData[0]) else $error("write protect cleared");
  a_lor_delay:
  assert property ($fell(lossrefResetOut_n) |-> sinceRst_q > 8'd128) else $error("lossref early");
endmodule // wdl_watchdog_chk

bind wdl_watchdog wdl_watchdog_chk u_chk (.sys_clk(sys_clk), .rst_b(rst_b),
  .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
  .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest), .debugMode(debugMode),
  .wdResetOut_n(wdResetOut_n), .lossrefResetOut_n(lossrefResetOut_n));

/* test/wdl_watchdog_tb.sv */
// wdl_watchdog_tb: self-checking bench of the watchdog block
`timescale 1ns/100ps
module wdl_watchdog_tb;
  logic sys_clk = 1'b0, rst_b = 1'b0, avsRead = 1'b0, avsWrite = 1'b0;
  logic waitMode = 1'b0, stopMode = 1'b0, debugMode = 1'b0, lorReq = 1'b0;
  logic [3:0] avsAddress = 4'h0;
  logic [31:0] avsWriteData = 32'h0, avsReadData;
  logic avsWaitRequest, wdResetOut_n, lossrefResetOut_n, lossOfRef, xo, ro;
  logic [31:0] expQ[$];
  logic [15:0] t;
  int n_fail = 0, compares = 0;
  initial forever #25 sys_clk = ~sys_clk;
  wdl_clk_monitor u_mon (.sys_clk(sys_clk), .lorReq(lorReq), .crystalOscClock(xo),
    .relaxationOscClock(ro), .lossOfRef(lossOfRef));
  wdl_watchdog uut (.sys_clk(sys_clk), .rst_b(rst_b), .avsAddress(avsAddress),
    .avsRead(avsRead), .avsWrite(avsWrite), .avsWriteData(avsWriteData),
    .avsByteEnable(4'hf), .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest),
    .waitMode(waitMode), .stopMode(stopMode), .debugMode(debugMode), .lossOfRef(lossOfRef),
    .crystalOscClock(xo), .relaxationOscClock(ro), .wdResetOut_n(wdResetOut_n),
    .lossrefResetOut_n(lossrefResetOut_n));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    if (n_fail == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avsAddress <= a;
    avsWrite <= w;
    avsRead <= !w;
    avsWriteData <= d;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avsWaitRequest !== 1'b0 && n < 20);
    if (n >= 20) begin
      n_fail++;
      test_done();
    end
    avsRead <= 1'b0;
    avsWrite <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    expQ.push_back(e);
    acc(1'b0, a, 32'h0);
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    acc(1'b1, a, {16'h0, d});
  endtask
  task automatic rst();
    rst_b <= 1'b0;
    repeat (12) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge sys_clk);
  endtask
  task automatic waitlow(input bit lor, input int lim);
    int n;
    n = 0;
    while ((lor ? lossrefResetOut_n : wdResetOut_n) !== 1'b0 && n < lim) begin
      @(posedge sys_clk);
      n++;
    end
  endtask
  // read results are judged where they appear, in request order
  always @(posedge sys_clk)
    if (avsRead && avsWaitRequest === 1'b0) chk(avsReadData, expQ.pop_front());
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_fail++;
    test_done();
  end
  initial begin
    void'($urandom(14));
    t = 16'h0020 + 16'($urandom_range(15));
    rst();
    rd(4'h0, 32'h302);
    rd(4'h4, 32'hffff);
    rd(4'h8, 32'hffff);
    rd(4'hc, 32'h0);
    wr(4'h0, 16'h0040);
    wr(4'h4, t);
    rd(4'h8, {16'h0, t});
    waitMode <= 1'b1;
    wr(4'h0, 16'h0042);
    repeat (6) @(posedge sys_clk);
    rd(4'h8, {16'h0, t});
    wr(4'h0, 16'h0046);
    waitlow(1'b0, 2 * t);
    chk(wdResetOut_n, 1'b0);
    waitMode <= 1'b0;
    rst();
    chk({wdResetOut_n, lossrefResetOut_n}, 2'b11);
    wr(4'h4, t);
    wr(4'h0, 16'h0040);
    stopMode <= 1'b1;
    wr(4'h0, 16'h0042);
    repeat (6) @(posedge sys_clk);
    rd(4'h8, {16'h0, t});
    debugMode <= 1'b1;
    wr(4'h0, 16'h004a);
    repeat (2 * t) @(posedge sys_clk);
    chk(wdResetOut_n, 1'b1);
    rd(4'h0, 32'h48);
    wr(4'h0, 16'h0048);
    wr(4'h4, t + 16'h0010);
    wr(4'h0, 16'h004a);
    rd(4'h8, {16'h0, t + 16'h0010});
    wr(4'h4, t);
    debugMode <= 1'b0;
    repeat (4) begin
      wr(4'h8, 16'h5555);
      rd(4'h4, {16'h0, t});
      wr(4'h8, 16'haaaa);
      repeat (t / 2) @(posedge sys_clk);
    end
    chk(wdResetOut_n, 1'b1);
    wr(4'h8, 16'h5555);
    wr(4'h8, 16'h1234);
    wr(4'h8, 16'haaaa);
    waitlow(1'b0, t);
    chk(wdResetOut_n, 1'b0);
    stopMode <= 1'b0;
    rst();
    wr(4'h0, 16'h0312);
    lorReq <= 1'b1;
    repeat (60) @(posedge sys_clk);
    wr(4'h0, 16'h0302);
    repeat (200) @(posedge sys_clk);
    chk(lossrefResetOut_n, 1'b1);
    wr(4'h0, 16'h0312);
    repeat (100) @(posedge sys_clk);
    wr(4'h8, 16'h5555);
    wr(4'h8, 16'haaaa);
    repeat (60) @(posedge sys_clk);
    chk(lossrefResetOut_n, 1'b1);
    waitlow(1'b1, 150);
    chk(lossrefResetOut_n, 1'b0);
    lorReq <= 1'b0;
    rst();
    wr(4'h0, 16'h0303);
    wr(4'h4, 16'($urandom));
    rd(4'h4, 32'hffff);
    wr(4'h0, 16'h0302);
    rd(4'h0, 32'h303);
    test_done();
  end
endmodule // wdl_watchdog_tb
